// *** verilog/rcw_pkg.sv ***
`default_nettype none

package rcw_pkg;

    // -----------------------------------------------------------------
    // Register map
    // -----------------------------------------------------------------
    localparam logic [7:0] ADR_WDCTRL = 8'h00;
    localparam logic [7:0] ADR_FLAGS = 8'h04;
    localparam logic [7:0] ADR_REFCTRL = 8'h08;
    localparam logic [7:0] ADR_RESTART = 8'h0C;
    localparam logic [7:0] ADR_STATUS = 8'h10;

    // -----------------------------------------------------------------
    // Field positions and reset values
    // -----------------------------------------------------------------
    localparam int WD_CE_BIT = 4;
    localparam int WD_EN_BIT = 3;
    localparam int WD_PER_W = 3;
    localparam logic [2:0] WD_PER_RST = 3'h0;
    localparam int FLG_POR = 0;
    localparam int FLG_EXT = 1;
    localparam int FLG_BOD = 2;
    localparam int FLG_WDOG = 3;
    localparam int FLG_TAP = 4;
    localparam int FLG_W = 5;
    localparam logic [4:0] FLG_POR_ONLY = 5'h01;
    localparam int REF_CMP_BIT = 0;
    localparam int REF_CONV_BIT = 1;
    localparam int ST_WDEN = 0;
    localparam int ST_LVL2 = 1;
    localparam int ST_BG = 2;
    localparam int ST_BODTRIP = 3;
    localparam int ST_INRST = 4;
    localparam logic [1:0] BOD_FUSE_OFF = 2'h3;
    localparam int CLOCK_SOURCE_FUSE_XTAL_BIT = 3;

    // -----------------------------------------------------------------
    // Synchroniser lanes
    // -----------------------------------------------------------------
    localparam int SY_POR = 0;
    localparam int SY_EXT = 1;
    localparam int SY_TAP = 2;
    localparam int SY_BOD = 3;
    localparam int SY_OSC = 4;
    localparam int SY_W = 5;

    // -----------------------------------------------------------------
    // Timing
    // -----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int CE_WINDOW_CYC = 4;
    localparam int BOD_MIN_NS = 2000;
    localparam int BOD_MIN_CYC = (BOD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        RS_HOLD = 2'b00,
        RS_COUNT = 2'b01,
        RS_RUN = 2'b11
    } rcw_rst_state_t;

endpackage : rcw_pkg

`default_nettype wire

// *** verilog/rcw_reset_ctrl.sv ***
// Behaviour
// - During reset all registers return to initial values; release starts vector fetch; here the reset-cause flags keep their values through it.
// - Any reset source forces the I/O reset at once, without a clock; brown-out and watchdog here act only on clock edges.
// - After all sources clear, reset stretches by a fuse-selected delay count.
// - Power-on, pin, watchdog, brown-out and test-port resets combine into one.
// - A low reset pin resets the device even with no clock running.
// - Pin release starts the delay counter; processor runs after timeout.
// - Power-on release starts the delay; supply drop reasserts reset instantly.
// - Enabled brown-out asserts reset at once, releases through the delay; here reset follows only after the BOD_MIN_CYC filter.
// - Brown-out is reported only when the dip outlasts the minimum time.
// - Watchdog expiry gives a one-cycle pulse; delay starts after it falls.
// - Reset holds while the test-port reset bit is one.
// - Bandgap on if brown-out enabled, comparator select set, or converter on; here it is off while a power-on, pin or test-port reset is held.
// - Watchdog counts edges of its own separate 1 MHz oscillator.
// - Watchdog counter clears on restart, when disabled, and on chip reset.
// - Eight timeout periods; expiry without restart resets the device.
// - Always-on fuse picks safety level 1 or 2 and start state.
// - In level 1 writing enable one enables without any sequence.
// - New values written with change-enable clear are taken only within four cycles.
// - Change-enable clears by itself four cycles after being set.
// - In level 2 enable reads one and cannot be cleared.
// - Period select gives 16K to 2048K oscillator cycles, doubling each step.
//
// The APB interface to the registers and the address map are this design's own decisions.

`default_nettype none

module rcw_reset_ctrl #(
    parameter int unsigned DLY_SHORT_CYC = 16,
    parameter int unsigned DLY_MID_CYC = 1024,
    parameter int unsigned DLY_LONG_CYC = 16384,
    parameter int unsigned DLY_OSC_CYC = 64,
    parameter int unsigned WDOG_BASE_OSC = 16384
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Reset sources
    input wire logic por_active_i,
    input wire logic ext_reset_b_i,
    input wire logic bod_low_i,
    input wire logic tap_reset_i,
    // Fuses
    input wire logic [1:0] startup_time_fuse_i,
    input wire logic [3:0] clock_source_fuse_i,
    input wire logic [1:0] brownout_level_fuse_i,
    input wire logic wdog_always_on_fuse_i,
    // Watchdog oscillator
    input wire logic wdog_osc_i,
    // APB slave
    input wire logic [7:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // System outputs
    output logic sys_reset_o,
    output logic vector_fetch_o,
    output logic bandgap_on_o
);
    import rcw_pkg::*;

    // -----------------------------------------------------------------
    // Declarations
    // -----------------------------------------------------------------
    logic hard_rst_b;
    logic [SY_W-1:0] sync_in;
    logic [SY_W-1:0] sync_m_q;
    logic [SY_W-1:0] sync_q;
    logic [1:0] rel_q;
    rcw_rst_state_t rst_st_q;
    logic [23:0] dly_cnt_q;
    logic [23:0] dly_tgt;
    logic stretch_q;
    logic vec_q;
    logic src_act;
    logic bod_en;
    logic [15:0] bod_cnt_q;
    logic bod_trip_q;
    logic lvl2;
    logic wd_en_q;
    logic wd_en_eff;
    logic [WD_PER_W-1:0] wd_per_q;
    logic ce_q;
    logic [1:0] ce_tmr_q;
    logic restart_q;
    logic osc_d_q;
    logic osc_edge;
    logic [21:0] wd_cnt_q;
    logic [21:0] wd_lim;
    logic wdog_fire_q;
    logic cmp_bg_q;
    logic conv_en_q;
    logic bandgap_q;
    logic [FLG_W-1:0] flags_q;
    logic [FLG_W-1:0] flg_set;
    logic [FLG_W-1:0] flg_d;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] rd_d;
    logic acc_first;
    logic wr_acc;
    logic wr_ctrl;
    logic open_seq;
    logic w_ce;
    logic w_en;

    function automatic logic rcw_mapped(input logic [7:0] a);
        rcw_mapped = (a == ADR_WDCTRL) || (a == ADR_FLAGS) || (a == ADR_REFCTRL)
            || (a == ADR_RESTART) || (a == ADR_STATUS);
    endfunction : rcw_mapped

    // Startup delay chosen by the startup-time and clock-source fuses.
    function automatic logic [23:0] rcw_dly(input logic [1:0] startup_time_fuse, input logic [3:0] cks);
        logic [23:0] base;
        base = 24'(DLY_LONG_CYC);
        case (startup_time_fuse)
            2'h0: base = 24'(DLY_SHORT_CYC);
            2'h1: base = 24'(DLY_MID_CYC);
            default: base = 24'(DLY_LONG_CYC);
        endcase
        if (cks[CLOCK_SOURCE_FUSE_XTAL_BIT]) begin
            base = base + 24'(DLY_OSC_CYC);
        end
        rcw_dly = base;
    endfunction : rcw_dly

    // -----------------------------------------------------------------
    // Source combination and synchronisers
    // -----------------------------------------------------------------
    // The raw sources act as an asynchronous reset so that the pin,
    // power-on and test-port resets work with the clock stopped.
    assign hard_rst_b = rst_b_i & ~por_active_i & ext_reset_b_i & ~tap_reset_i;

    assign sync_in[SY_POR] = por_active_i;
    assign sync_in[SY_EXT] = ~ext_reset_b_i;
    assign sync_in[SY_TAP] = tap_reset_i;
    assign sync_in[SY_BOD] = bod_low_i;
    assign sync_in[SY_OSC] = wdog_osc_i;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync_m_q <= '0;
            sync_q <= '0;
        end else begin
            sync_m_q <= sync_in;
            sync_q <= sync_m_q;
        end
    end

    // -----------------------------------------------------------------
    // Brown-out filter
    // -----------------------------------------------------------------
    assign bod_en = (brownout_level_fuse_i != BOD_FUSE_OFF);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bod_cnt_q <= '0;
            bod_trip_q <= 1'b0;
        end else if (!bod_en || !sync_q[SY_BOD]) begin
            bod_cnt_q <= '0;
            bod_trip_q <= 1'b0;
        end else if (bod_cnt_q == 16'(BOD_MIN_CYC - 1)) begin
            bod_trip_q <= 1'b1;
        end else begin
            bod_cnt_q <= bod_cnt_q + 16'h0001;
        end
    end

    // -----------------------------------------------------------------
    // Reset stretch
    // -----------------------------------------------------------------
    assign dly_tgt = rcw_dly(startup_time_fuse_i, clock_source_fuse_i);
    assign src_act = !rel_q[1] || bod_trip_q || wdog_fire_q;

    always_ff @(posedge clk_i or negedge hard_rst_b) begin
        if (!hard_rst_b) begin
            rel_q <= 2'b00;
            rst_st_q <= RS_HOLD;
            dly_cnt_q <= '0;
            stretch_q <= 1'b1;
            vec_q <= 1'b0;
        end else begin
            rel_q <= {rel_q[0], 1'b1};
            vec_q <= 1'b0;
            case (rst_st_q)
                RS_HOLD: begin
                    stretch_q <= 1'b1;
                    dly_cnt_q <= '0;
                    if (!src_act) begin
                        rst_st_q <= RS_COUNT;
                    end
                end
                RS_COUNT: begin
                    if (src_act) begin
                        rst_st_q <= RS_HOLD;
                        dly_cnt_q <= '0;
                    end else if (dly_cnt_q == dly_tgt - 24'h000001) begin
                        rst_st_q <= RS_RUN;
                        stretch_q <= 1'b0;
                        vec_q <= 1'b1;
                    end else begin
                        dly_cnt_q <= dly_cnt_q + 24'h000001;
                    end
                end
                RS_RUN: begin
                    if (src_act) begin
                        rst_st_q <= RS_HOLD;
                        stretch_q <= 1'b1;
                    end
                end
                default: begin
                    rst_st_q <= RS_HOLD;
                    stretch_q <= 1'b1;
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // APB slave
    // -----------------------------------------------------------------
    // One wait state: pready rises in the second access cycle, which
    // gives read data a full cycle from the address decode.
    assign acc_first = psel_i && penable_i && !pready_q;
    assign wr_acc = psel_i && penable_i && pready_q && pwrite_i;
    assign wr_ctrl = wr_acc && (paddr_i == ADR_WDCTRL);
    assign w_ce = pwdata_i[WD_CE_BIT];
    assign w_en = pwdata_i[WD_EN_BIT];
    assign open_seq = wr_ctrl && w_ce && w_en;

    always_comb begin
        rd_d = 32'h00000000;
        case (paddr_i)
            ADR_WDCTRL: begin
                rd_d[WD_CE_BIT] = ce_q;
                rd_d[WD_EN_BIT] = wd_en_eff;
                rd_d[WD_PER_W-1:0] = wd_per_q;
            end
            ADR_FLAGS: rd_d[FLG_W-1:0] = flags_q;
            ADR_REFCTRL: begin
                rd_d[REF_CMP_BIT] = cmp_bg_q;
                rd_d[REF_CONV_BIT] = conv_en_q;
            end
            ADR_STATUS: begin
                rd_d[ST_WDEN] = wd_en_eff;
                rd_d[ST_LVL2] = lvl2;
                rd_d[ST_BG] = bandgap_q;
                rd_d[ST_BODTRIP] = bod_trip_q;
                rd_d[ST_INRST] = stretch_q;
            end
            default: rd_d = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            pready_q <= acc_first;
            if (acc_first) begin
                pslverr_q <= !rcw_mapped(paddr_i);
                prdata_q <= pwrite_i ? 32'h00000000 : rd_d;
            end
        end
    end

    // -----------------------------------------------------------------
    // Reset cause flags (write zero to clear)
    // -----------------------------------------------------------------
    assign flg_set[FLG_POR] = sync_q[SY_POR];
    assign flg_set[FLG_EXT] = sync_q[SY_EXT];
    assign flg_set[FLG_BOD] = bod_trip_q;
    assign flg_set[FLG_WDOG] = wdog_fire_q;
    assign flg_set[FLG_TAP] = sync_q[SY_TAP];

    always_comb begin
        flg_d = flags_q;
        if (wr_acc && (paddr_i == ADR_FLAGS)) begin
            flg_d = flg_d & pwdata_i[FLG_W-1:0];
        end
        // A cause that arrives with the clearing write is kept.
        flg_d = flg_d | flg_set;
        if (flg_set[FLG_POR]) begin
            flg_d = FLG_POR_ONLY;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flags_q <= FLG_POR_ONLY;
        end else begin
            flags_q <= flg_d;
        end
    end

    // -----------------------------------------------------------------
    // Watchdog control and timed sequence
    // -----------------------------------------------------------------
    assign lvl2 = wdog_always_on_fuse_i;
    assign wd_en_eff = wd_en_q || lvl2;

    always_ff @(posedge clk_i or negedge hard_rst_b) begin
        if (!hard_rst_b) begin
            wd_en_q <= 1'b0;
            wd_per_q <= WD_PER_RST;
            ce_q <= 1'b0;
            ce_tmr_q <= '0;
        end else if (stretch_q) begin
            wd_en_q <= 1'b0;
            wd_per_q <= WD_PER_RST;
            ce_q <= 1'b0;
            ce_tmr_q <= '0;
        end else begin
            if (open_seq) begin
                ce_q <= 1'b1;
                ce_tmr_q <= 2'(CE_WINDOW_CYC - 1);
                wd_en_q <= 1'b1;
            end else if (ce_q) begin
                if (ce_tmr_q == 2'h0) begin
                    ce_q <= 1'b0;
                end else begin
                    ce_tmr_q <= ce_tmr_q - 2'h1;
                end
            end
            if (wr_ctrl && !w_ce && ce_q) begin
                wd_per_q <= pwdata_i[WD_PER_W-1:0];
                if (!lvl2) begin
                    wd_en_q <= w_en;
                end
            end else if (wr_ctrl && !w_ce && w_en) begin
                wd_en_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge hard_rst_b) begin
        if (!hard_rst_b) begin
            restart_q <= 1'b0;
            cmp_bg_q <= 1'b0;
            conv_en_q <= 1'b0;
            bandgap_q <= 1'b0;
        end else begin
            restart_q <= wr_acc && (paddr_i == ADR_RESTART);
            if (stretch_q) begin
                cmp_bg_q <= 1'b0;
                conv_en_q <= 1'b0;
            end else if (wr_acc && (paddr_i == ADR_REFCTRL)) begin
                cmp_bg_q <= pwdata_i[REF_CMP_BIT];
                conv_en_q <= pwdata_i[REF_CONV_BIT];
            end
            bandgap_q <= bod_en || cmp_bg_q || conv_en_q;
        end
    end

    // -----------------------------------------------------------------
    // Watchdog counter
    // -----------------------------------------------------------------
    // Counting oscillator edges on the system clock needs the system
    // clock to run well above the oscillator rate.
    assign osc_edge = sync_q[SY_OSC] && !osc_d_q;
    assign wd_lim = (22'(WDOG_BASE_OSC) << wd_per_q) - 22'h000001;

    always_ff @(posedge clk_i or negedge hard_rst_b) begin
        if (!hard_rst_b) begin
            osc_d_q <= 1'b0;
            wd_cnt_q <= '0;
            wdog_fire_q <= 1'b0;
        end else begin
            osc_d_q <= sync_q[SY_OSC];
            wdog_fire_q <= 1'b0;
            if (stretch_q || !wd_en_eff || restart_q) begin
                wd_cnt_q <= '0;
            end else if (osc_edge) begin
                if (wd_cnt_q == wd_lim) begin
                    wd_cnt_q <= '0;
                    wdog_fire_q <= 1'b1;
                end else begin
                    wd_cnt_q <= wd_cnt_q + 22'h000001;
                end
            end
        end
    end

    // -----------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------
    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign sys_reset_o = stretch_q;
    assign vector_fetch_o = vec_q;
    assign bandgap_on_o = bandgap_q;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!hard_rst_b);

    chk_ce_auto_clear: assert property (
        $rose(ce_q) ##1 (!open_seq)[*3] |-> ##1 !ce_q)
        else $error("change enable did not clear after four cycles");

    chk_lvl2_always_on: assert property (
        lvl2 && !stretch_q && !restart_q && osc_edge && wd_cnt_q != wd_lim
        |=> wd_cnt_q == $past(wd_cnt_q) + 22'h000001)
        else $error("watchdog not counting in safety level 2");

    chk_fire_one_cycle: assert property (
        wdog_fire_q |=> !wdog_fire_q ##0 stretch_q)
        else $error("watchdog pulse not one cycle or reset missing");

    chk_bandgap_follows: assert property (
        !(bod_en || cmp_bg_q || conv_en_q) ##1 !(bod_en || cmp_bg_q || conv_en_q)
        |-> !bandgap_q)
        else $error("bandgap on with no user");

    chk_no_late_disable: assert property (
        wr_ctrl && !w_ce && !ce_q && wd_en_q && !stretch_q |=> wd_en_q)
        else $error("watchdog disabled outside the window");

    chk_lvl1_enable: assert property (
        wr_ctrl && w_en && !stretch_q |=> wd_en_q)
        else $error("enable write ignored");

    chk_release_delay: assert property (
        $fell(stretch_q) |-> $past(dly_cnt_q) == dly_tgt - 24'h000001 && vec_q)
        else $error("reset released before the delay ended");

    chk_bod_immediate: assert property (
        $rose(bod_trip_q) |=> stretch_q)
        else $error("brown-out did not assert reset");

    chk_wd_clear_off: assert property (
        !wd_en_eff ##1 !wd_en_eff |-> wd_cnt_q == 22'h000000)
        else $error("watchdog counter runs while disabled");

endmodule : rcw_reset_ctrl

`default_nettype wire

// *** dv/rcw_far_side.sv ***
`default_nettype none

module rcw_far_side (
    // Clock
    input wire logic clk_i,
    // Reset sources and watchdog oscillator
    output logic por_active_o,
    output logic ext_reset_b_o,
    output logic bod_low_o,
    output logic tap_reset_o,
    output logic wdog_osc_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // The supply starts below its threshold, so power-on is active from time zero.
    initial begin
        por_active_o = 1'b1;
        ext_reset_b_o = 1'b1;
        bod_low_o = 1'b0;
        tap_reset_o = 1'b0;
        wdog_osc_o = 1'b0;
        forever #500 wdog_osc_o = ~wdog_osc_o;
    end

    task automatic set(input int src);
        @(posedge clk_i);
        case (src)
            0: por_active_o <= 1'b1;
            1: ext_reset_b_o <= 1'b0;
            2: bod_low_o <= 1'b1;
            default: tap_reset_o <= 1'b1;
        endcase
    endtask : set

    task automatic clear();
        @(posedge clk_i);
        por_active_o <= 1'b0;
        ext_reset_b_o <= 1'b1;
        bod_low_o <= 1'b0;
        tap_reset_o <= 1'b0;
    endtask : clear
endmodule : rcw_far_side

`default_nettype wire

// *** dv/test_reset_control_with_watchdog.sv ***
`default_nettype none

module test_reset_control_with_watchdog;
    timeunit 1ns;
    timeprecision 1ps;
    import rcw_pkg::*;

    localparam int DLY = 8;
    localparam int OSC = 250;

    logic clk_i;
    logic rst_b_i;
    logic [1:0] bod_fuse;
    logic aon_fuse;
    logic [7:0] paddr_i;
    logic psel_i;
    logic penable_i;
    logic pwrite_i;
    logic [31:0] pwdata_i;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic sys_reset_o;
    logic vector_fetch_o;
    logic bandgap_on_o;
    wire por_w;
    wire ext_b_w;
    wire bod_w;
    wire tap_w;
    wire osc_w;
    logic [31:0] rv;
    logic rerr;
    logic held;
    int miscompares;
    int checks_done;

    rcw_far_side rcw_far_side_i (
        .clk_i(clk_i), .por_active_o(por_w), .ext_reset_b_o(ext_b_w),
        .bod_low_o(bod_w), .tap_reset_o(tap_w), .wdog_osc_o(osc_w)
    );

    rcw_reset_ctrl #(.DLY_SHORT_CYC(DLY), .WDOG_BASE_OSC(4)) rcw_reset_ctrl_i (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .por_active_i(por_w), .ext_reset_b_i(ext_b_w),
        .bod_low_i(bod_w), .tap_reset_i(tap_w), .startup_time_fuse_i(2'h0),
        .clock_source_fuse_i(4'h0), .brownout_level_fuse_i(bod_fuse),
        .wdog_always_on_fuse_i(aon_fuse), .wdog_osc_i(osc_w), .paddr_i(paddr_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .sys_reset_o(sys_reset_o), .vector_fetch_o(vector_fetch_o),
        .bandgap_on_o(bandgap_on_o)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic conclude();
        if (miscompares == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            miscompares++;
            $display("mismatch at %0t seen %0h expected %0h", $time, seen, want);
        end
    endtask : check

    // A kept transfer leaves psel high so the next setup follows at once.
    // Ready, read data and error are all taken at the rising edge that ends the access.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic k);
        if (!held) @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        rv = prdata_o;
        rerr = pslverr_o;
        penable_i <= 1'b0;
        if (!k) psel_i <= 1'b0;
        held = k;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic k);
        apb(1'b1, a, d, k);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0, 1'b0);
    endtask : rd

    task automatic wait_for(input logic lvl, output int n);
        n = 0;
        while (sys_reset_o !== lvl && n < 3000) begin
            @(negedge clk_i);
            n++;
        end
    endtask : wait_for

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_power_on();
        int n;
        rcw_far_side_i.clear();
        wait_for(1'b0, n);
        check(32'(n >= DLY && n <= DLY + 6), 32'h1);
        check(32'(vector_fetch_o), 32'h1);
        @(negedge clk_i);
        check(32'(vector_fetch_o), 32'h0);
        rd(ADR_FLAGS);
        check(rv, 32'(FLG_POR_ONLY));
        rd(8'h40);
        check({rv[30:0], rerr}, 32'h1);
    endtask : t_power_on

    task automatic t_src(input int src, input int lo, input int hi, input logic [31:0] flag);
        int n;
        wr(ADR_FLAGS, 32'h0, 1'b0);
        rcw_far_side_i.set(src);
        #1;
        wait_for(1'b1, n);
        check(32'(n >= lo && n <= hi), 32'h1);
        repeat (20) @(negedge clk_i);
        check(32'(sys_reset_o), 32'h1);
        rcw_far_side_i.clear();
        wait_for(1'b0, n);
        check(32'(n >= DLY && n <= DLY + 8), 32'h1);
        rd(ADR_FLAGS);
        check(rv, flag);
    endtask : t_src

    task automatic t_dip();
        rcw_far_side_i.set(2);
        repeat (BOD_MIN_CYC - 50) @(negedge clk_i);
        rcw_far_side_i.clear();
        rd(ADR_FLAGS);
        check(rv, 32'h10);
    endtask : t_dip

    task automatic t_bg();
        @(posedge clk_i);
        bod_fuse <= BOD_FUSE_OFF;
        for (int i = 3; i >= 0; i--) begin
            wr(ADR_REFCTRL, 32'(i), 1'b0);
            repeat (2) @(negedge clk_i);
            check(32'(bandgap_on_o), 32'(i != 0));
        end
        @(posedge clk_i);
        bod_fuse <= 2'h0;
        repeat (2) @(negedge clk_i);
        check(32'(bandgap_on_o), 32'h1);
    endtask : t_bg

    task automatic t_wd1();
        int n;
        rd(ADR_STATUS);
        check(32'(rv[ST_WDEN]), 32'h0);
        wr(ADR_WDCTRL, 32'h08, 1'b0);
        wr(ADR_WDCTRL, 32'h00, 1'b0);
        rd(ADR_STATUS);
        check(32'(rv[ST_WDEN]), 32'h1);
        wr(ADR_RESTART, 32'h0, 1'b0);
        wait_for(1'b1, n);
        check(32'(n >= 3 * OSC - 10 && n <= 4 * OSC + 12), 32'h1);
        wait_for(1'b0, n);
        rd(ADR_FLAGS);
        check(rv & 32'h08, 32'h08);
        t_src(1, 0, 0, 32'h02);
        wr(ADR_WDCTRL, 32'h08, 1'b0);
        wr(ADR_WDCTRL, 32'h18, 1'b1);
        rd(ADR_WDCTRL);
        check(rv, 32'h18);
        rd(ADR_WDCTRL);
        check(rv, 32'h08);
        wr(ADR_WDCTRL, 32'h18, 1'b0);
        repeat (4) @(posedge clk_i);
        wr(ADR_WDCTRL, 32'h01, 1'b0);
        rd(ADR_WDCTRL);
        check(rv, 32'h08);
        wr(ADR_WDCTRL, 32'h18, 1'b1);
        wr(ADR_WDCTRL, 32'h09, 1'b0);
        wr(ADR_FLAGS, 32'h0, 1'b0);
        for (int i = 0; i < 12; i++) begin
            repeat (300) @(posedge clk_i);
            wr(ADR_RESTART, 32'h0, 1'b0);
        end
        rd(ADR_FLAGS);
        check(rv, 32'h0);
        wait_for(1'b1, n);
        check(32'(n >= 7 * OSC - 10 && n <= 8 * OSC + 12), 32'h1);
        wait_for(1'b0, n);
    endtask : t_wd1

    // The fuse is static, so it changes only ahead of a full pin reset.
    task automatic t_wd2();
        int n;
        @(posedge clk_i);
        aon_fuse <= 1'b1;
        t_src(1, 0, 0, 32'h02);
        rd(ADR_STATUS);
        check(rv & 32'h03, 32'h03);
        wr(ADR_WDCTRL, 32'h18, 1'b1);
        wr(ADR_WDCTRL, 32'h00, 1'b0);
        rd(ADR_WDCTRL);
        check(rv, 32'h08);
        wr(ADR_RESTART, 32'h0, 1'b0);
        wait_for(1'b1, n);
        check(32'(n >= 3 * OSC - 10 && n <= 4 * OSC + 12), 32'h1);
    endtask : t_wd2

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    initial begin
        rst_b_i = 1'b0;
        bod_fuse = 2'h0;
        aon_fuse = 1'b0;
        paddr_i = 8'h00;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        pwdata_i = 32'h0;
        held = 1'b0;
        miscompares = 0;
        checks_done = 0;
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_power_on();
        t_src(0, 0, 0, 32'h01);
        t_src(1, 0, 0, 32'h02);
        t_src(3, 0, 0, 32'h10);
        t_dip();
        t_src(2, BOD_MIN_CYC, BOD_MIN_CYC + 8, 32'h04);
        t_bg();
        t_wd1();
        t_wd2();
        conclude();
    end

    initial begin
        #(4 * 30000);
        miscompares++;
        conclude();
    end
endmodule : test_reset_control_with_watchdog

`default_nettype wire
